// file: verilog/pmc_pkg.sv
package pmc_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] PMC_CTRL_OFF   = 8'h00;
    localparam logic [7:0] PMC_STAT_OFF   = 8'h04;
    localparam logic [7:0] PMC_IRQ_OFF    = 8'h08;
    localparam logic [7:0] PMC_MASK_OFF   = 8'h0c;
    localparam logic [7:0] PMC_DET_OFF    = 8'h10;

    // Control register fields
    localparam int CTRL_SLEEP_BIT   = 0;
    localparam int CTRL_STOP_BIT    = 1;
    localparam int CTRL_STDBY_BIT   = 2;
    localparam int CTRL_LPREG_BIT   = 3;
    // Detector config fields
    localparam int DET_EN_BIT       = 0;
    localparam int DET_FALL_BIT     = 1;
    localparam int DET_RISE_BIT     = 2;
    // Interrupt status fields
    localparam int IRQ_FALL_BIT     = 0;
    localparam int IRQ_RISE_BIT     = 1;
    localparam int IRQ_WAKE_BIT     = 2;
    localparam int IRQ_W            = 3;

    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [2:0]  DET_RESET   = 3'h0;
    localparam logic [2:0]  MASK_RESET  = 3'h0;

    // Reset hold after supply good: 1 us at 250 MHz
    localparam int HOLD_NS          = 1000;
    localparam int CLK_NS           = 4;
    localparam int HOLD_CYC         = (HOLD_NS + CLK_NS - 1) / CLK_NS;

    localparam int EXT_LINES        = 23;

    typedef enum logic [1:0] {
        BOOT_FLASH  = 2'h0,
        BOOT_SYSMEM = 2'h1,
        BOOT_SRAM   = 2'h2
    } pmc_boot_type;

    typedef enum logic [1:0] {
        REG_MAIN    = 2'h0,
        REG_LOWPWR  = 2'h1,
        REG_OFF     = 2'h2
    } pmc_reg_type;

    // Gray path: RUN -> SLEEP, RUN -> STDBY; RUN -> STOP flips both bits
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_STOP  = 2'b11,
        ST_STDBY = 2'b10
    } pmc_state_type;

    typedef struct packed {
        logic cpuClkEn;
        logic coreClkEn;
        logic pllEn;
        logic fastRcEn;
        logic fastXtalEn;
        logic sysClkIsRc;
    } pmc_clk_type;

    typedef struct packed {
        logic extResetPin;
        logic watchdogReset;
        logic wakeupPin;
        logic rtcAlarm;
    } pmc_stdby_wake_type;

endpackage : pmc_pkg

// file: verilog/pmc_supervisor.sv
`timescale 1ns/1ps
module pmc_supervisor
    import pmc_pkg::*;
#(
    parameter int HOLD = HOLD_CYC
) (
    input  wire logic clock,        // System clock
    input  wire logic reset,        // Async reset
    input  wire logic mainSupplyOk, // Main supply above threshold
    input  wire logic anaSupplyOk,  // Analog supply above threshold
    input  wire logic anaWatchOff,  // Option: skip analog watch
    output logic      holdReset     // Device held in reset
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        hold;
    } pmc_sup_state_type;

    pmc_sup_state_type s_q;
    pmc_sup_state_type s_d;
    logic              supplyGood;

    always_comb begin
        supplyGood = mainSupplyOk && (anaWatchOff || anaSupplyOk);
        s_d = s_q;
        if (!supplyGood) begin
            s_d.cnt  = '0;
            s_d.hold = 1'b1;
        end else if (s_q.cnt < 16'(HOLD)) begin
            s_d.cnt  = s_q.cnt + 16'h0001;
            s_d.hold = 1'b1;
        end else begin
            s_d.hold = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q <= '{cnt: 16'h0000, hold: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign holdReset = s_q.hold;

endmodule : pmc_supervisor

// file: verilog/pmc_power_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Sleep gates only processor clock
// - Any peripheral interrupt ends sleep
// - Stop gates core clocks, fast oscillators
// - Stop regulator mode chosen by software
// - Any event line ends stop
// - Standby powers off regulator and core
// - Standby exits on four wake events
// - RTC and watchdog clocks never stopped
// - Regulator main, low-power, off per mode
// - Regulator enabled after reset, off standby
// - Supervisors hold reset while supply low
// - Power-on and power-down both; option skips analog
// - Detector interrupts on fall/rise as set
// - Detector inactive until software enables
// - Boot pin and option pick source
// - Internal fast RC selected after reset
module pmc_power_ctrl
    import pmc_pkg::*;
#(
    parameter int LINES = EXT_LINES
) (
    input  wire logic               clock,         // 250 MHz clock
    input  wire logic               reset,         // Async reset
    // AXI4-Lite slave
    input  wire logic [7:0]         s_awaddr,      // Write address
    input  wire logic               s_awvalid,     // Write addr valid
    output logic                    s_awready,     // Write addr ready
    input  wire logic [31:0]        s_wdata,       // Write data
    input  wire logic [3:0]         s_wstrb,       // Byte enables
    input  wire logic               s_wvalid,      // Write data valid
    output logic                    s_wready,      // Write data ready
    output logic [1:0]              s_bresp,       // Write response
    output logic                    s_bvalid,      // Write resp valid
    input  wire logic               s_bready,      // Write resp ready
    input  wire logic [7:0]         s_araddr,      // Read address
    input  wire logic               s_arvalid,     // Read addr valid
    output logic                    s_arready,     // Read addr ready
    output logic [31:0]             s_rdata,       // Read data
    output logic [1:0]              s_rresp,       // Read response
    output logic                    s_rvalid,      // Read data valid
    input  wire logic               s_rready,      // Read data ready
    // Core and wake sources
    input  wire logic               cpuWaitReq,    // Core asks to sleep
    input  wire logic               periphIrq,     // Any peripheral irq
    input  wire logic [LINES-1:0]   eventLines,    // Event line levels
    input  wire pmc_stdby_wake_type stdbyWake,     // Standby wake inputs
    // Supplies and straps
    input  wire logic               mainSupplyOk,  // Main supply good
    input  wire logic               anaSupplyOk,   // Analog supply good
    input  wire logic               anaWatchOff,   // Option bit
    input  wire logic               levelAbove,    // Detector comparator
    input  wire logic               bootSelectPin, // Boot strap pin
    input  wire logic               bootSelectOpt, // Boot option bit
    // Outputs
    output pmc_clk_type             clkCtl,        // Clock/osc controls
    output logic                    slowClkEn,     // RTC/watchdog clocks
    output pmc_reg_type             regMode,       // Regulator mode
    output logic                    regEnable,     // Regulator enabled
    output logic                    coreReset,     // Core held in reset
    output pmc_boot_type            bootSource,    // Latched boot source
    output logic                    irq            // Interrupt level
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        pmc_state_type mode;
        logic [3:0]    ctrl;
        logic [2:0]    det;
        logic [2:0]    irqStat;
        logic [2:0]    irqMask;
        logic          aboveOld;
        logic          wakePinOld;
        logic          bootDone;
        pmc_boot_type  boot;
        logic          awDone;
        logic          wDone;
        logic [7:0]    awAddr;
        logic [31:0]   wData;
        logic [3:0]    wStrb;
        logic          bValid;
        logic [1:0]    bResp;
        logic          rValid;
        logic [31:0]   rData;
        logic [1:0]    rResp;
        pmc_clk_type   clk;
        pmc_reg_type   regSel;
        logic          regEn;
        logic          coreRst;
        logic          irqOut;
    } pmc_top_state_type;

    pmc_top_state_type s_q;
    pmc_top_state_type s_d;
    logic              holdReset;
    logic              stdbyExit;
    logic              wakeEdge;
    logic              doWrite;
    logic [31:0]       wMerged;
    logic [31:0]       curWord;
    logic [31:0]       rdWord;
    logic [1:0]        rdResp;
    logic [2:0]        irqSet;

    pmc_supervisor #(
        .HOLD(HOLD_CYC)
    ) u_sup (
        .clock       (clock),
        .reset       (reset),
        .mainSupplyOk(mainSupplyOk),
        .anaSupplyOk (anaSupplyOk),
        .anaWatchOff (anaWatchOff),
        .holdReset   (holdReset)
    );

    always_comb begin
        s_d      = s_q;
        irqSet   = 3'h0;
        wMerged  = 32'h0000_0000;
        curWord  = 32'h0000_0000;
        rdWord   = 32'h0000_0000;
        rdResp   = 2'h0;

        // ************************************************************
        // Detector and wake edges
        // ************************************************************
        s_d.aboveOld   = levelAbove;
        s_d.wakePinOld = stdbyWake.wakeupPin;
        wakeEdge = stdbyWake.wakeupPin && !s_q.wakePinOld;
        if (s_q.det[DET_EN_BIT]) begin
            irqSet[IRQ_FALL_BIT] = s_q.det[DET_FALL_BIT]
                                   && s_q.aboveOld && !levelAbove;
            irqSet[IRQ_RISE_BIT] = s_q.det[DET_RISE_BIT]
                                   && !s_q.aboveOld && levelAbove;
        end

        stdbyExit = stdbyWake.extResetPin || stdbyWake.watchdogReset
                    || wakeEdge || stdbyWake.rtcAlarm;

        // ************************************************************
        // Mode machine
        // ************************************************************
        case (s_q.mode)
            ST_RUN: begin
                if (cpuWaitReq && s_q.ctrl[CTRL_STDBY_BIT]) begin
                    s_d.mode = ST_STDBY;
                end else if (cpuWaitReq && s_q.ctrl[CTRL_STOP_BIT]) begin
                    s_d.mode = ST_STOP;
                end else if (cpuWaitReq) begin
                    s_d.mode = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (periphIrq || |eventLines) begin
                    s_d.mode = ST_RUN;
                end
            end
            ST_STOP: begin
                if (|eventLines) begin
                    s_d.mode = ST_RUN;
                    irqSet[IRQ_WAKE_BIT] = 1'b1;
                end
            end
            ST_STDBY: begin
                if (stdbyExit) begin
                    s_d.mode    = ST_RUN;
                    s_d.ctrl    = CTRL_RESET[3:0];
                    s_d.det     = DET_RESET;
                    s_d.irqMask = MASK_RESET;
                    s_d.irqStat = 3'h0;
                    s_d.coreRst = 1'b1;
                end
            end
            default: s_d.mode = ST_RUN;
        endcase

        // ************************************************************
        // Clock and regulator outputs
        // ************************************************************
        s_d.clk.cpuClkEn   = (s_d.mode == ST_RUN);
        s_d.clk.coreClkEn  = (s_d.mode == ST_RUN)
                             || (s_d.mode == ST_SLEEP);
        s_d.clk.pllEn      = s_d.clk.coreClkEn;
        s_d.clk.fastRcEn   = s_d.clk.coreClkEn;
        s_d.clk.fastXtalEn = s_d.clk.coreClkEn;
        s_d.clk.sysClkIsRc = 1'b1;
        case (s_d.mode)
            ST_STOP:  s_d.regSel = s_q.ctrl[CTRL_LPREG_BIT] ? REG_LOWPWR
                                                            : REG_MAIN;
            ST_STDBY: s_d.regSel = REG_OFF;
            default:  s_d.regSel = REG_MAIN;
        endcase
        s_d.regEn = (s_d.mode != ST_STDBY);
        if (s_q.mode != ST_STDBY || !stdbyExit) begin
            s_d.coreRst = holdReset || (s_d.mode == ST_STDBY);
        end

        // ************************************************************
        // Boot source, caught once after reset release
        // ************************************************************
        // boot source select
        if (!s_q.bootDone && !holdReset) begin
            s_d.bootDone = 1'b1;
            if (!bootSelectPin) begin
                s_d.boot = BOOT_FLASH;
            end else if (bootSelectOpt) begin
                s_d.boot = BOOT_SYSMEM;
            end else begin
                s_d.boot = BOOT_SRAM;
            end
        end

        // ************************************************************
        // AXI4-Lite slave
        // ************************************************************
        if (s_awvalid && !s_q.awDone) begin
            s_d.awDone = 1'b1;
            s_d.awAddr = s_awaddr;
        end
        if (s_wvalid && !s_q.wDone) begin
            s_d.wDone = 1'b1;
            s_d.wData = s_wdata;
            s_d.wStrb = s_wstrb;
        end
        doWrite = s_q.awDone && s_q.wDone && !s_q.bValid;
        case (s_q.awAddr)
            PMC_CTRL_OFF: curWord = {28'h0, s_q.ctrl};
            PMC_MASK_OFF: curWord = {29'h0, s_q.irqMask};
            PMC_DET_OFF:  curWord = {29'h0, s_q.det};
            default:      curWord = 32'h0000_0000;
        endcase
        for (int i = 0; i < 4; i++) begin
            wMerged[i*8 +: 8] = s_q.wStrb[i] ? s_q.wData[i*8 +: 8]
                                             : curWord[i*8 +: 8];
        end
        s_d.irqStat = s_d.irqStat;
        if (doWrite) begin
            s_d.awDone = 1'b0;
            s_d.wDone  = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp  = 2'h0;
            case (s_q.awAddr)
                PMC_CTRL_OFF: s_d.ctrl    = wMerged[3:0];
                PMC_MASK_OFF: s_d.irqMask = wMerged[2:0];
                PMC_DET_OFF:  s_d.det     = wMerged[2:0];
                PMC_IRQ_OFF:  s_d.irqStat = s_q.irqStat & ~wMerged[2:0];
                PMC_STAT_OFF: s_d.bResp   = 2'h0;
                default:      s_d.bResp   = 2'h2;
            endcase
        end
        if (s_q.bValid && s_bready) begin
            s_d.bValid = 1'b0;
        end
        // Set wins over a write-one-to-clear in the same cycle
        s_d.irqStat = s_d.irqStat | irqSet;
        s_d.irqOut  = |(s_d.irqStat & s_d.irqMask);

        case (s_araddr)
            PMC_CTRL_OFF: rdWord = {28'h0, s_q.ctrl};
            PMC_STAT_OFF: rdWord = {26'h0, s_q.boot, s_q.regEn,
                                    levelAbove, s_q.mode};
            PMC_IRQ_OFF:  rdWord = {29'h0, s_q.irqStat};
            PMC_MASK_OFF: rdWord = {29'h0, s_q.irqMask};
            PMC_DET_OFF:  rdWord = {29'h0, s_q.det};
            default:      rdResp = 2'h2;
        endcase
        if (s_arvalid && !s_q.rValid) begin
            s_d.rValid = 1'b1;
            s_d.rData  = rdWord;
            s_d.rResp  = rdResp;
        end else if (s_q.rValid && s_rready) begin
            s_d.rValid = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q         <= '0;
            s_q.mode    <= ST_RUN;
            s_q.boot    <= BOOT_FLASH;
            s_q.regSel  <= REG_MAIN;
            s_q.regEn   <= 1'b1;
            s_q.coreRst <= 1'b1;
            s_q.clk     <= '{cpuClkEn: 1'b1, coreClkEn: 1'b1,
                             pllEn: 1'b1, fastRcEn: 1'b1,
                             fastXtalEn: 1'b1, sysClkIsRc: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign slowClkEn  = 1'b1;
    assign clkCtl     = s_q.clk;
    assign regMode    = s_q.regSel;
    assign regEnable  = s_q.regEn;
    assign coreReset  = s_q.coreRst;
    assign bootSource = s_q.boot;
    assign irq        = s_q.irqOut;
    assign s_awready  = !s_q.awDone;
    assign s_wready   = !s_q.wDone;
    assign s_bvalid   = s_q.bValid;
    assign s_bresp    = s_q.bResp;
    assign s_arready  = !s_q.rValid;
    assign s_rvalid   = s_q.rValid;
    assign s_rdata    = s_q.rData;
    assign s_rresp    = s_q.rResp;

endmodule : pmc_power_ctrl

// file: tb/pmc_power_ctrl_asserts.sv
`timescale 1ns/1ps
module pmc_power_ctrl_asserts
    import pmc_pkg::*;
#(
    parameter int LINES = EXT_LINES
) (
    input wire logic             clock,        // System clock
    input wire logic             reset,        // Async reset
    input wire logic             periphIrq,    // Peripheral irq
    input wire logic [LINES-1:0] eventLines,   // Event lines
    input wire logic             mainSupplyOk, // Main supply good
    input wire pmc_clk_type      clkCtl,       // Clock controls
    input wire logic             slowClkEn,    // RTC/watchdog clocks
    input wire pmc_reg_type      regMode,      // Regulator mode
    input wire logic             regEnable,    // Regulator on
    input wire logic             coreReset     // Core held
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // ****************************************************************
    // Mode sequences
    // ****************************************************************
    sequence s_sleep; !clkCtl.cpuClkEn && clkCtl.coreClkEn; endsequence
    sequence s_stop; !clkCtl.coreClkEn && regEnable; endsequence
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_sleep_only;
        !clkCtl.cpuClkEn && clkCtl.fastRcEn |-> clkCtl.coreClkEn;
    endproperty
    a_sleep_only: assert property (p_sleep_only)
        else $error("peripheral clock lost in sleep");
    property p_sleep_wake; s_sleep ##0 periphIrq |=> clkCtl.cpuClkEn;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("irq did not end sleep");
    property p_stop_gate; !clkCtl.coreClkEn |->
        !(clkCtl.pllEn || clkCtl.fastRcEn || clkCtl.fastXtalEn);
    endproperty
    a_stop_gate: assert property (p_stop_gate)
        else $error("oscillator on with core clocks off");
    property p_stop_reg; s_stop |-> regMode inside {REG_MAIN, REG_LOWPWR};
    endproperty
    a_stop_reg: assert property (p_stop_reg)
        else $error("bad regulator mode in stop");
    property p_stop_wake; s_stop ##0 (|eventLines) |=> clkCtl.coreClkEn;
    endproperty
    a_stop_wake: assert property (p_stop_wake)
        else $error("event line did not end stop");
    property p_slow; slowClkEn; endproperty
    a_slow: assert property (p_slow)
        else $error("slow clocks stopped");
    property p_reg_off; !regEnable |->
        regMode == REG_OFF && !clkCtl.coreClkEn && !clkCtl.pllEn;
    endproperty
    a_reg_off: assert property (p_reg_off)
        else $error("regulator off outside standby");
    property p_hold; !mainSupplyOk [*3] |-> coreReset; endproperty
    a_hold: assert property (p_hold)
        else $error("core not held with supply low");
    property p_wake_rst; $rose(regEnable) |-> ##[0:2] coreReset;
    endproperty
    a_wake_rst: assert property (p_wake_rst)
        else $error("standby exit without reset");
    property p_rc; $fell(coreReset) |-> clkCtl.sysClkIsRc; endproperty
    a_rc: assert property (p_rc)
        else $error("reset left without RC clock");
endmodule : pmc_power_ctrl_asserts

bind pmc_power_ctrl pmc_power_ctrl_asserts #(.LINES(LINES)) u_chk (
    .clock, .reset, .periphIrq, .eventLines, .mainSupplyOk,
    .clkCtl, .slowClkEn, .regMode, .regEnable, .coreReset
);

// file: tb/pmc_core_model.sv
`timescale 1ns/1ps
module pmc_core_model
    import pmc_pkg::*;
(
    input  wire logic        clock,      // System clock
    input  wire logic        reset,      // Async reset
    input  wire logic        sleepCmd,   // Bench asks core to idle
    input  wire pmc_clk_type clkCtl,     // Clock controls
    input  wire logic        coreReset,  // Core held
    output logic             cpuWaitReq  // Low-power request
);
    // A gated or held core cannot keep asking, so the request drops
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cpuWaitReq <= 1'b0;
        end else begin
            cpuWaitReq <= sleepCmd && clkCtl.cpuClkEn && !coreReset;
        end
    end
endmodule : pmc_core_model

// file: tb/pmc_power_ctrl_tb.sv
`timescale 1ns/1ps
module pmc_power_ctrl_tb;
    import pmc_pkg::*;
    localparam int L = EXT_LINES;
    logic               clock, reset, sleepCmd, cpuWaitReq, periphIrq;
    logic               awValid, wValid, bReady, arValid, rReady;
    logic               awReady, wReady, bValid, arReady, rValid;
    logic [7:0]         awAddr, arAddr;
    logic [31:0]        wData, rData, rdv;
    logic [1:0]         bResp, rResp, resp;
    logic [L-1:0]       eventLines;
    pmc_stdby_wake_type stdbyWake;
    logic               mainSupplyOk, anaSupplyOk, anaWatchOff, levelAbove;
    logic               bootSelectPin, bootSelectOpt, slowClkEn, regEnable;
    logic               coreReset, irq;
    pmc_clk_type        clkCtl;
    pmc_reg_type        regMode;
    pmc_boot_type       bootSource;
    int                 error_cnt, checked;

    pmc_power_ctrl pmc_power_ctrl_inst (
        .clock, .reset, .s_awaddr(awAddr), .s_awvalid(awValid),
        .s_awready(awReady), .s_wdata(wData), .s_wstrb(4'hf),
        .s_wvalid(wValid), .s_wready(wReady), .s_bresp(bResp),
        .s_bvalid(bValid), .s_bready(bReady), .s_araddr(arAddr),
        .s_arvalid(arValid), .s_arready(arReady), .s_rdata(rData),
        .s_rresp(rResp), .s_rvalid(rValid), .s_rready(rReady),
        .cpuWaitReq, .periphIrq, .eventLines, .stdbyWake, .mainSupplyOk,
        .anaSupplyOk, .anaWatchOff, .levelAbove, .bootSelectPin,
        .bootSelectOpt, .clkCtl, .slowClkEn, .regMode, .regEnable,
        .coreReset, .bootSource, .irq
    );
    pmc_core_model pmc_core_model_inst (
        .clock, .reset, .sleepCmd, .clkCtl, .coreReset, .cpuWaitReq
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1
    task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask : chk2
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awAddr  <= a;
        wData   <= d;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        do begin
            @(posedge clock);
            if (awReady === 1'b1) awValid <= 1'b0;
            if (wReady === 1'b1) wValid <= 1'b0;
        end while (bValid !== 1'b1);
        bReady <= 1'b0;
        resp = bResp;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        do begin
            @(posedge clock);
            if (arReady === 1'b1) arValid <= 1'b0;
        end while (rValid !== 1'b1);
        rReady <= 1'b0;
        rdv = rData;
        resp = rResp;
        chk(rdv, exp);
    endtask : rdc
    task automatic rel;
        do @(posedge clock); while (coreReset !== 1'b0);
        #1;
    endtask : rel
    task automatic ent(input logic [31:0] c);
        wr(PMC_CTRL_OFF, c);
        @(posedge clock);
        sleepCmd <= 1'b1;
        do @(posedge clock); while (clkCtl.cpuClkEn !== 1'b0);
        sleepCmd <= 1'b0;
        #1;
    endtask : ent
    task automatic close_out;
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_boot;
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            bootSelectPin <= (i != 0);
            bootSelectOpt <= (i == 1);
            reset         <= 1'b1;
            repeat (3) @(posedge clock);
            #1;
            chk({26'h0, clkCtl}, 32'h3f);
            chk1(regEnable, 1'b1);
            chk2(regMode, REG_MAIN);
            reset <= 1'b0;
            rel();
            chk2(bootSource, (i == 0) ? BOOT_FLASH :
                 (i == 1) ? BOOT_SYSMEM : BOOT_SRAM);
        end
        rdc(PMC_CTRL_OFF, CTRL_RESET);
        rdc(PMC_MASK_OFF, {29'h0, MASK_RESET});
        rdc(PMC_DET_OFF, {29'h0, DET_RESET});
        rdc(8'h40, 32'h0);
        chk2(resp, 2'h2);
        wr(8'h40, 32'h1);
        chk2(resp, 2'h2);
        $display("boot done");
    endtask : t_boot
    task automatic t_sleep;
        ent(32'h0);
        chk({28'h0, clkCtl.cpuClkEn, clkCtl.coreClkEn,
             clkCtl.fastRcEn, regEnable}, 32'h7);
        periphIrq <= 1'b1;
        @(posedge clock);
        #1;
        chk1(clkCtl.cpuClkEn, 1'b1);
        periphIrq <= 1'b0;
        $display("sleep done");
    endtask : t_sleep
    task automatic t_stop;
        for (int lp = 0; lp < 2; lp++) begin
            ent(32'(1 << CTRL_STOP_BIT) | 32'(lp << CTRL_LPREG_BIT));
            chk({28'h0, clkCtl.coreClkEn, clkCtl.pllEn,
                 clkCtl.fastRcEn, clkCtl.fastXtalEn}, 32'h0);
            chk2(regMode, lp ? REG_LOWPWR : REG_MAIN);
            chk1(slowClkEn, 1'b1);
            eventLines <= (lp != 0) ? L'(1) << (L - 1) : L'(1);
            @(posedge clock);
            #1;
            chk1(clkCtl.coreClkEn, 1'b1);
            chk2(regMode, REG_MAIN);
            eventLines <= '0;
            rdc(PMC_IRQ_OFF, 32'h4);
            wr(PMC_IRQ_OFF, 32'h4);
        end
        $display("stop done");
    endtask : t_stop
    task automatic t_stdby;
        for (int i = 0; i < 4; i++) begin
            ent(32'(1 << CTRL_STDBY_BIT));
            eventLines <= '1;
            periphIrq  <= 1'b1;
            repeat (3) @(posedge clock);
            #1;
            chk1(regEnable, 1'b0);
            chk2(regMode, REG_OFF);
            eventLines <= '0;
            periphIrq  <= 1'b0;
            stdbyWake  <= pmc_stdby_wake_type'(4'h8 >> i);
            @(posedge clock);
            stdbyWake <= '0;
            @(posedge clock);
            #1;
            chk1(regEnable, 1'b1);
            rel();
            rdc(PMC_CTRL_OFF, 32'h0);
        end
        $display("standby done");
    endtask : t_stdby
    task automatic t_det;
        wr(PMC_DET_OFF, 32'h0);
        levelAbove <= 1'b0;
        repeat (4) @(posedge clock);
        levelAbove <= 1'b1;
        rdc(PMC_IRQ_OFF, 32'h0);
        wr(PMC_DET_OFF, 32'(1 << DET_EN_BIT | 1 << DET_FALL_BIT |
                            1 << DET_RISE_BIT));
        for (int k = 0; k < 3; k++) begin
            wr(PMC_MASK_OFF, (k == 0) ? 32'h0 : 32'h3);
            levelAbove <= k[0];
            rdc(PMC_IRQ_OFF, 32'h1 << k[0]);
            chk1(irq, k != 0);
            wr(PMC_IRQ_OFF, 32'h1 << k[0]);
            @(posedge clock);
            #1;
            chk1(irq, 1'b0);
        end
        $display("detector done");
    endtask : t_det
    task automatic t_supply;
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            mainSupplyOk <= (i != 0);
            anaSupplyOk  <= (i == 0);
            anaWatchOff  <= (i == 2);
            repeat (8) @(posedge clock);
            #1;
            chk1(coreReset, i != 2);
            mainSupplyOk <= 1'b1;
            anaSupplyOk  <= 1'b1;
            anaWatchOff  <= 1'b0;
            if (i != 2) rel();
        end
        $display("supply done");
    endtask : t_supply

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        {reset, mainSupplyOk, anaSupplyOk, levelAbove} = 4'hf;
        {sleepCmd, periphIrq, anaWatchOff, bootSelectPin} = 4'h0;
        {awValid, wValid, bReady, arValid, rReady, bootSelectOpt} = 6'h0;
        {awAddr, arAddr, wData, eventLines} = '0;
        stdbyWake = '0;
        error_cnt = 0;
        checked   = 0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        t_boot();
        t_sleep();
        t_stop();
        t_stdby();
        t_det();
        t_supply();
        close_out();
    end
    // Whole run is near 1500 cycles; the 50000-cycle limit means a hang
    initial begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule : pmc_power_ctrl_tb
